// [spi_flash_wrap_and_page_buffer.sv]
// serial command sequencer: burst-wrap setting and sram page buffer
//
// Behaviour
// - opcode 77h sets wrap on/off and length
// - 77h opcode single line, rest quad
// - 77h address six quad clocks, discarded
// - eight wrap bits, only bits 6:4 used
// - bit4 low: 8/16/32/64 wrap; high: linear
// - later quad reads confined to wrap line
// - wrapped read runs to line end, wraps
// - non-byte-boundary release aborts, no change
// - buffer read single line in and out
// - read address low byte selects entry
// - read data msb first, any length
// - read past last entry continues at zero
// - release ends read, output goes floating
// - buffer write all on serial input
// - write address low byte is start entry
// - write bytes successive entries, wrap to zero
// - buffer never cleared before write
// - page program sweeps all 256 entries
// - complete 06h then release sets latch
// - latch-gated command skipped when latch clear
`timescale 1ns/100ps
`default_nettype none
module spi_flash_wrap_and_page_buffer (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  output logic write_enable_latch_o,
  output logic [2:0] wrap_config_bits_o,
  input wire logic rd_load_i,
  input wire logic [23:0] rd_addr_i,
  input wire logic rd_step_i,
  output logic [23:0] rd_addr_o,
  output logic pgm_valid_o,
  output logic [7:0] pgm_idx_o,
  output logic [7:0] pgm_data_o
);
  import wrap_buf_pkg::*;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic sck_prev;
  logic cs_prev;
  logic cs_s;
  logic [3:0] io_s;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  seq_state_t st;
  logic [7:0] sh;
  logic [7:0] cmd;
  logic [4:0] cnt;
  logic [2:0] tot3;
  logic done;
  logic [7:0] addr;
  logic [2:0] wrap_new;
  logic [7:0] page_mem [256];
  logic [7:0] out_byte;
  logic [7:0] raddr;
  logic [2:0] obit;
  logic pgm_run;
  logic [7:0] sweep;
  logic quad;
  logic [4:0] nb;
  logic [4:0] next_cnt;
  logic [4:0] plen;
  logic phase_end;
  logic [7:0] shin;
  logic commit;
  logic pgm_go;
  logic mem_we;
  logic [7:0] line_mask;
  logic [7:0] lo_inc;
  logic [7:0] stage_mem [256];
  logic [255:0] stage_v;
  logic wr_commit;

  // two-stage sync of chip select, clock and data lines
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      pin_s1 <= 6'h3F;
      pin_s2 <= 6'h3F;
      sck_prev <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      pin_s1 <= {cs_n_i, sck_i, io_i};
      pin_s2 <= pin_s1;
      sck_prev <= pin_s2[4];
      cs_prev <= pin_s2[5];
    end
  end

  // edges are taken after the sync so data and clock stay aligned
  assign cs_s = pin_s2[5];
  assign io_s = pin_s2[3:0];
  assign sck_rise = pin_s2[4] & ~sck_prev & ~cs_s;
  assign sck_fall = ~pin_s2[4] & sck_prev & ~cs_s;
  assign cs_rise = cs_s & ~cs_prev;

  // quad lanes only for address and wrap bits of 77h
  assign quad = (st == ST_ADDR || st == ST_WRAP) && cmd == OP_WRAP;
  assign nb = quad ? QUAD_STEP : SINGLE_STEP;
  assign next_cnt = cnt + nb;
  assign plen = (st == ST_ADDR) ? ADDR_BITS : BYTE_BITS;
  assign phase_end = next_cnt == plen;
  // msb first in both widths; io3 carries the top nibble bit
  assign shin = quad ? {sh[3:0], io_s} : {sh[6:0], io_s[0]};
  // release counts only on a whole byte after a complete command
  assign commit = cs_rise && tot3 == 3'h0 && done;
  assign pgm_go = commit && cmd == OP_PGM && write_enable_latch_o &&
                  !pgm_run;
  assign mem_we = sck_rise && st == ST_WDATA && phase_end;
  // staged bytes reach the buffer only on a clean byte-boundary release
  assign wr_commit = commit && cmd == OP_BUF_WR;

  // command sequencer, restarted by every chip-select release
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      st <= ST_OPC;
      sh <= 8'h00;
      cmd <= 8'h00;
      cnt <= 5'h00;
      tot3 <= 3'h0;
      done <= 1'b0;
      addr <= 8'h00;
      wrap_new <= WRAP_RESET;
    end else if (cs_s) begin
      st <= ST_OPC;
      cnt <= 5'h00;
      tot3 <= 3'h0;
      done <= 1'b0;
    end else if (sck_rise) begin
      sh <= shin;
      tot3 <= tot3 + nb[2:0];
      cnt <= phase_end ? 5'h00 : next_cnt;
      case (st)
        ST_OPC: begin
          if (phase_end) begin
            cmd <= shin;
            done <= shin == OP_WREN || shin == OP_WRDI;
            if (shin == OP_WRAP || shin == OP_BUF_RD ||
                shin == OP_BUF_WR || shin == OP_PGM) begin
              st <= ST_ADDR;
            end else begin
              st <= ST_IDLE;
            end
          end
        end
        ST_ADDR: begin
          if (phase_end) begin
            addr <= shin;
            case (cmd)
              OP_WRAP: st <= ST_WRAP;
              OP_BUF_RD: st <= ST_DUMMY;
              OP_BUF_WR: begin
                done <= write_enable_latch_o;
                st <= write_enable_latch_o ? ST_WDATA : ST_IDLE;
              end
              default: begin
                done <= 1'b1;
                st <= ST_IDLE;
              end
            endcase
          end
        end
        ST_WRAP: begin
          if (phase_end) begin
            wrap_new <= shin[WRAP_HI:WRAP_LO];
            done <= 1'b1;
            st <= ST_IDLE;
          end
        end
        ST_DUMMY: begin
          if (phase_end) begin
            st <= ST_RDATA;
          end
        end
        ST_WDATA: begin
          if (phase_end) begin
            addr <= addr + 8'h01;
          end
        end
        default: begin
          st <= st;
        end
      endcase
    end
  end

  // write bytes staged per frame; a cut frame must leave the buffer intact
  always_ff @(posedge clock_i) begin
    if (mem_we) begin
      stage_mem[addr] <= shin;
    end
  end

  // staged-entry marks, dropped at every release
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      stage_v <= {256{1'b0}};
    end else if (cs_s) begin
      stage_v <= {256{1'b0}};
    end else if (mem_we) begin
      stage_v[addr] <= 1'b1;
    end
  end

  // commit marked entries only; untouched entries keep old data
  for (genvar i = 0; i < 256; i++) begin : g_buf
    always_ff @(posedge clock_i) begin
      if (wr_commit && stage_v[i]) begin
        page_mem[i] <= stage_mem[i];
      end
    end
  end

  // read data shifted out on falling clock, msb first
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      out_byte <= 8'h00;
      raddr <= 8'h00;
      obit <= 3'h0;
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
    end else begin
      io_oe_o[SO_LANE] <= st == ST_RDATA && !cs_s;
      if (sck_rise && st == ST_DUMMY && phase_end) begin
        out_byte <= page_mem[addr];
        raddr <= addr + 8'h01;
        obit <= 3'h0;
      end else if (sck_fall && st == ST_RDATA) begin
        io_o[SO_LANE] <= out_byte[~obit];
        obit <= obit + 3'h1;
        if (obit == 3'h7) begin
          out_byte <= page_mem[raddr];
          raddr <= raddr + 8'h01;
        end
      end
    end
  end

  // write-enable latch: set by 06h, cleared by 04h or program end
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      write_enable_latch_o <= 1'b0;
    end else if (commit && cmd == OP_WREN) begin
      write_enable_latch_o <= 1'b1;
    end else if (commit && cmd == OP_WRDI) begin
      write_enable_latch_o <= 1'b0;
    end else if (pgm_run && sweep == BUF_LAST) begin
      write_enable_latch_o <= 1'b0;
    end
  end

  // wrap setting is volatile and resets to linear
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      wrap_config_bits_o <= WRAP_RESET;
    end else if (commit && cmd == OP_WRAP) begin
      wrap_config_bits_o <= wrap_new;
    end
  end

  // program sweep hands every entry to the array writer
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      pgm_run <= 1'b0;
      sweep <= 8'h00;
      pgm_valid_o <= 1'b0;
      pgm_idx_o <= 8'h00;
      pgm_data_o <= 8'h00;
    end else begin
      if (pgm_go) begin
        pgm_run <= 1'b1;
        sweep <= 8'h00;
      end else if (pgm_run) begin
        sweep <= sweep + 8'h01;
        if (sweep == BUF_LAST) begin
          pgm_run <= 1'b0;
        end
      end
      pgm_valid_o <= pgm_run;
      pgm_idx_o <= sweep;
      pgm_data_o <= page_mem[sweep];
    end
  end

  // line mask from wrap size code
  always_comb begin
    case (wrap_config_bits_o[2:1])
      2'h0: line_mask = MASK_8;
      2'h1: line_mask = MASK_16;
      2'h2: line_mask = MASK_32;
      default: line_mask = MASK_64;
    endcase
  end
  assign lo_inc = rd_addr_o[7:0] + 8'h01;

  // read address walker; only the low byte moves inside a line
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rd_addr_o <= 24'h000000;
    end else if (rd_load_i) begin
      rd_addr_o <= rd_addr_i;
    end else if (rd_step_i) begin
      if (wrap_config_bits_o[0]) begin
        rd_addr_o <= rd_addr_o + 24'h000001;
      end else begin
        rd_addr_o[7:0] <= (rd_addr_o[7:0] & ~line_mask) |
                          (lo_inc & line_mask);
      end
    end
  end

  AST_WRAP_ONLY_ON_RELEASE: assert property (
    $changed(wrap_config_bits_o) |-> $past(commit))
    else $error("wrap setting changed without a valid release");

  AST_ABORT_NO_CHANGE: assert property (
    cs_rise && tot3 != 3'h0 |=> $stable(wrap_config_bits_o) &&
    $stable(write_enable_latch_o))
    else $error("partial-byte release changed state");

  AST_WEL_SET: assert property (
    commit && cmd == OP_WREN |=> write_enable_latch_o)
    else $error("write enable latch not set");

  AST_SO_FLOAT: assert property (
    cs_s |=> !io_oe_o[SO_LANE])
    else $error("serial output driven while deselected");

  AST_WRITE_NEEDS_WEL: assert property (
    $rose(st == ST_WDATA) |-> $past(write_enable_latch_o))
    else $error("buffer write entered with latch clear");

  AST_WRAP_STAYS_IN_LINE: assert property (
    rd_step_i && !rd_load_i && !wrap_config_bits_o[0] |=>
    rd_addr_o[23:6] == $past(rd_addr_o[23:6]))
    else $error("wrapped read left its line");

  AST_LINEAR_STEP: assert property (
    rd_step_i && !rd_load_i && wrap_config_bits_o[0] |=>
    rd_addr_o == $past(rd_addr_o) + 24'h000001)
    else $error("linear read did not increment");

  AST_SWEEP_START: assert property (
    $rose(pgm_valid_o) |-> pgm_idx_o == 8'h00)
    else $error("program sweep did not start at entry zero");

  AST_SWEEP_END: assert property (
    $fell(pgm_valid_o) |-> $past(pgm_idx_o) == BUF_LAST)
    else $error("program sweep ended early");
endmodule
`default_nettype wire

// [wrap_buf_pkg.sv]
// constants and types for the wrap-setting and page-buffer sequencer
package wrap_buf_pkg;
  localparam logic [7:0] OP_WRAP = 8'h77;
  localparam logic [7:0] OP_BUF_RD = 8'hD4;
  localparam logic [7:0] OP_BUF_WR = 8'h84;
  localparam logic [7:0] OP_PGM = 8'h88;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] QUAD_STEP = 5'h04;
  localparam logic [4:0] SINGLE_STEP = 5'h01;
  localparam logic [2:0] WRAP_RESET = 3'h1;
  localparam int WRAP_HI = 6;
  localparam int WRAP_LO = 4;
  localparam logic [7:0] BUF_LAST = 8'hFF;
  localparam logic [7:0] MASK_8 = 8'h07;
  localparam logic [7:0] MASK_16 = 8'h0F;
  localparam logic [7:0] MASK_32 = 8'h1F;
  localparam logic [7:0] MASK_64 = 8'h3F;
  localparam int SO_LANE = 1;
  typedef enum logic [2:0] {
    ST_OPC = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b010,
    ST_WRAP = 3'b011,
    ST_RDATA = 3'b100,
    ST_WDATA = 3'b101,
    ST_IDLE = 3'b110
  } seq_state_t;
endpackage

// [spi_host_model.sv]
// host-side serial flash controller model, spi mode 0
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input wire logic clock_i,
  input wire logic so_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic [3:0] io_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o
);
  logic s;
  // idle levels; sck stands low outside frames
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    io_o = 4'h5;
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
  end
  // one 80 ns sck period; so sampled late in the high phase for margin
  task automatic tick();
    repeat (4) @(negedge clock_i);
    sck_o = 1'b1;
    repeat (4) @(negedge clock_i);
    s = so_i;
    sck_o = 1'b0;
  endtask
  task automatic start();
    @(negedge clock_i);
    cs_n_o = 1'b0;
  endtask
  // lanes invert on release so a stale level never passes for data
  task automatic stop();
    repeat (4) @(negedge clock_i);
    cs_n_o = 1'b1;
    io_o = ~io_o;
    repeat (8) @(negedge clock_i);
  endtask
  // single-line bit on lane 0; other lanes churn as junk
  task automatic bit1(input logic b);
    io_o = {~io_o[3:1], b};
    tick();
  endtask
  task automatic send8(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      bit1(v[i]);
    end
  endtask
  // quad clock, lane 3 carries the nibble msb
  task automatic nib(input logic [3:0] n);
    io_o = n;
    tick();
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a);
    start();
    send8(op);
    send8(a[23:16]);
    send8(a[15:8]);
    send8(a[7:0]);
  endtask
  task automatic cmd1(input logic [7:0] op);
    start();
    send8(op);
    stop();
  endtask
  // one byte msb first, handed to the bench monitor as a pulse
  task automatic rd_byte();
    for (int i = 0; i < 8; i++) begin
      tick();
      rx_byte_o = {rx_byte_o[6:0], s};
    end
    rx_valid_o = 1'b1;
    @(negedge clock_i);
    rx_valid_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// [spi_flash_wrap_and_page_buffer_tb.sv]
// self-checking bench for the wrap setting and page buffer sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); \
  end \
end
module spi_flash_wrap_and_page_buffer_tb;
  import wrap_buf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_load = 1'b0;
  logic rd_step = 1'b0;
  logic [23:0] rd_addr = 24'h000000;
  logic cs_n, sck, rx_valid, write_enable_latch, pgm_valid;
  logic [3:0] h_io, d_io, d_oe, pin_io;
  logic [23:0] walk, exp_a;
  logic [2:0] wrap;
  logic [7:0] pgm_idx, pgm_data, rx_byte, wb, a0, m, e8;
  logic [7:0] mem [256];
  logic [7:0] rdq [$];
  int num_errors = 0;
  int n_compared = 0;
  int sweep_n = 0;
  always #5 clk = ~clk;
  // pin level: the device wins only on lanes it enables
  assign pin_io = (d_oe & d_io) | (~d_oe & h_io);
  spi_host_model u_spi_host_model (.clock_i(clk), .so_i(pin_io[1]),
    .cs_n_o(cs_n), .sck_o(sck), .io_o(h_io), .rx_valid_o(rx_valid),
    .rx_byte_o(rx_byte));
  spi_flash_wrap_and_page_buffer u_spi_flash_wrap_and_page_buffer (
    .clock_i(clk), .reset_n_i(rst_n), .cs_n_i(cs_n), .sck_i(sck),
    .io_i(pin_io), .io_o(d_io), .io_oe_o(d_oe),
    .write_enable_latch_o(write_enable_latch), .wrap_config_bits_o(wrap),
    .rd_load_i(rd_load), .rd_addr_i(rd_addr), .rd_step_i(rd_step),
    .rd_addr_o(walk), .pgm_valid_o(pgm_valid), .pgm_idx_o(pgm_idx),
    .pgm_data_o(pgm_data));
  task automatic stop_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // buffer read of n bytes, then a release in mid-byte
  task automatic rd(input logic [7:0] a, input int n);
    u_spi_host_model.cmd(OP_BUF_RD, {16'($urandom), a});
    u_spi_host_model.send8(8'($urandom));
    for (int i = 0; i < n; i++) begin
      rdq.push_back(mem[8'(a + i)]);
      u_spi_host_model.rd_byte();
    end
    u_spi_host_model.bit1(1'b1);
    `CHK(d_oe[1], 1'b1)
    u_spi_host_model.stop();
    `CHK(d_oe, 4'h0)
  endtask
  // buffer write; without keep a stray partial byte aborts the frame
  task automatic wr(input logic [7:0] a, input int n, input logic keep);
    u_spi_host_model.cmd(OP_BUF_WR, {16'($urandom), a});
    for (int i = 0; i < n; i++) begin
      wb = 8'($urandom);
      if (keep) mem[8'(a + i)] = wb;
      u_spi_host_model.send8(wb);
    end
    if (!keep) repeat (3) u_spi_host_model.bit1(1'b1);
    u_spi_host_model.stop();
  endtask
  // wrap setting; short form stops after half the wrap byte
  task automatic set_wrap(input logic [7:0] w, input logic full);
    u_spi_host_model.start();
    u_spi_host_model.send8(OP_WRAP);
    repeat (6) u_spi_host_model.nib(4'($urandom));
    u_spi_host_model.nib(w[7:4]);
    if (full) u_spi_host_model.nib(w[3:0]);
    u_spi_host_model.stop();
  endtask
  // result monitor: read bytes against the queue, sweep against the model
  always @(posedge clk) begin
    if (rx_valid) begin
      e8 = rdq.pop_front();
      `CHK(rx_byte, e8)
    end
    if (pgm_valid === 1'b1) begin
      `CHK(pgm_idx, 8'(sweep_n))
      `CHK(pgm_data, mem[8'(sweep_n)])
      sweep_n++;
    end
  end
  initial begin
    #800000;
    num_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(95));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    `CHK(wrap, WRAP_RESET)
    `CHK(write_enable_latch, 1'b0)
    // every wrap code, junk in unused bits, walker checked for each
    for (int c = 0; c < 8; c++) begin
      wb = 8'($urandom);
      wb[6:4] = 3'(c);
      set_wrap(wb, 1'b1);
      `CHK(wrap, wb[6:4])
      set_wrap(~wb, 1'b0);
      `CHK(wrap, wb[6:4])
      m = (8'h08 << wb[6:5]) - 8'h01;
      rd_addr = 24'($urandom);
      rd_load = 1'b1;
      exp_a = rd_addr;
      @(negedge clk);
      rd_load = 1'b0;
      rd_step = 1'b1;
      repeat (70) begin
        `CHK(walk, exp_a)
        exp_a = wb[4] ? exp_a + 24'h000001 : {exp_a[23:8],
          (exp_a[7:0] & ~m) | ((exp_a[7:0] + 8'h01) & m)};
        @(negedge clk);
      end
      rd_step = 1'b0;
    end
    // fill the whole buffer with overrun, then read across the end
    u_spi_host_model.cmd1(OP_WREN);
    `CHK(write_enable_latch, 1'b1)
    a0 = 8'($urandom);
    wr(a0, 258, 1'b1);
    rd(8'hFB, 9);
    wr(a0 + 8'h01, 1, 1'b1);
    rd(a0, 3);
    wr(a0, 4, 1'b0);
    rd(a0, 4);
    u_spi_host_model.cmd1(OP_WRDI);
    `CHK(write_enable_latch, 1'b0)
    wr(a0, 2, 1'b0);
    rd(a0, 2);
    u_spi_host_model.cmd(OP_PGM, 24'($urandom));
    u_spi_host_model.stop();
    repeat (300) @(negedge clk);
    `CHK(sweep_n, 0)
    u_spi_host_model.cmd1(OP_WREN);
    u_spi_host_model.cmd(OP_PGM, 24'($urandom));
    u_spi_host_model.stop();
    repeat (300) @(negedge clk);
    `CHK(sweep_n, 256)
    `CHK(write_enable_latch, 1'b0)
    `CHK(rdq.size(), 0)
    stop_test();
  end
endmodule
`default_nettype wire
